// file: core/cgc_top.sv
`timescale 1ns/1ps
module cgc_top import cgc_pkg::*; (
	input wire logic MCLK, // controller clock, 25 MHz
	input wire logic RST_B, // hardware reset, active low
	input wire logic [7:0] SFR_ADDR, // special-function address
	input wire logic [7:0] SFR_WDATA, // write data
	input wire logic SFR_WR, // write strobe, one cycle
	input wire logic SFR_RD, // read strobe, one cycle
	output logic [7:0] SFR_RDATA, // read data, valid the cycle after SFR_RD
	input wire logic CAN_RX, // bus receive pin, asynchronous
	output logic CAN_TX, // bus transmit pin
	input wire logic ENG_TX_BIT, // engine transmit bit
	input wire logic ENG_ACK_BIT, // engine ack bit, low drives ack dominant
	input wire logic FRAME_ACTIVE, // engine: frame on the bus in progress
	input wire logic RX_MSG_DONE, // engine: message received, pulse
	input wire logic OVL_TX_START, // engine: overload frame begins, pulse
	input wire logic OVL_TX_ACTIVE, // engine: overload frame being sent
	input wire logic SOF_SEEN, // engine: start of frame, pulse
	input wire logic EOF_LAST, // engine: last bit of end of frame, pulse
	input wire logic TX_DONE, // engine: transmission ended ok, pulse
	input wire logic RX_DONE, // engine: reception ended ok, pulse
	input wire logic TX_BUSY, // engine: transmitter busy
	input wire logic RX_BUSY, // engine: receiver busy
	input wire logic BUS_OFF, // engine: bus-off state
	input wire logic ERR_PASSIVE, // engine: error-passive state
	output logic RX_DATA, // synchronised receive bit to engine
	output logic RX_ENABLE, // receiver active
	output logic ENG_RUN, // protocol engine may run
	output logic CLK_GATE_EN, // controller clock ungated
	output logic CORE_RST_B, // controller reset, active low
	output logic OBJ_EN_CLR, // clear every object_enable, pulse
	output logic TX_ABORT, // drop pending transmissions, level
	output logic OVL_FRAME_REQ, // send an overload frame, level
	output logic TTC_MODE, // time-triggered mode active
	output logic TIMER_CAPTURE, // capture trigger timer, pulse
	output logic LISTEN_MODE, // listening mode active
	output logic ERR_CNT_FREEZE, // hold error counters
	output logic TRANSMIT_OK_FLAG_SET, // set transmit_ok_flag of current object, pulse
	output logic RECEIVE_OK_FLAG_SET // set receive_ok_flag of current object, pulse
);
	logic [7:0] ctrl_ff; // general_control_reg storage
	logic [7:0] nxt_ctrl; // its next value
	logic soft_rst_ff; // soft reset pending this cycle
	logic ovl_pending_ff; // overload armed by a received message
	logic abort_seen_ff; // abort bit as seen last cycle
	cgc_en_state_type en_state_ff; // enable sequencing
	logic start_done; // start delay elapsed
	logic rx_sync; // synchronised receive pin
	logic enabled; // actual enabled state
	logic ctrl_wr; // write to control register
	logic [7:0] stat_word; // general_status_reg image

	assign ctrl_wr = SFR_WR && (SFR_ADDR == CGC_CTRL_ADDR);
	assign enabled = (en_state_ff == EN_ON) || (en_state_ff == EN_STOPPING);

	// pin passes two flops before anything reads it
	cgc_sync2 u_rx_sync (
		.clk(MCLK),
		.rst_b(RST_B),
		.rst_val(1'b1),
		.d_in(CAN_RX),
		.q_out(rx_sync)
	);

	// start delay runs while the sequencer waits for the engine
	cgc_delay_cnt u_start (
		.clk(MCLK),
		.rst_b(RST_B),
		.start(en_state_ff == EN_STARTING),
		.done(start_done)
	);

	// control register next value; registers reachable in any enable state
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (ctrl_wr) begin
			nxt_ctrl = SFR_WDATA;
			nxt_ctrl[CGC_SOFT_RESET_BIT] = 1'b0;
		end
		// hardware clear of the overload request, unless software sets it now
		if (OVL_TX_START && !(ctrl_wr && SFR_WDATA[CGC_OVERLOAD_REQUEST_BIT])) begin
			nxt_ctrl[CGC_OVERLOAD_REQUEST_BIT] = 1'b0;
		end
		// soft reset wipes the register, enable included
		if (soft_rst_ff) begin
			nxt_ctrl = CGC_CTRL_RST;
		end
	end

	// control register; the test bit resets to zero though software may not rely on it
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_ff <= CGC_CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// soft reset lasts exactly one cycle
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			soft_rst_ff <= 1'b0;
		end else begin
			soft_rst_ff <= ctrl_wr && SFR_WDATA[CGC_SOFT_RESET_BIT];
		end
	end

	// controller reset: hardware reset or the soft reset pulse
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			CORE_RST_B <= 1'b0;
		end else begin
			CORE_RST_B <= !(ctrl_wr && SFR_WDATA[CGC_SOFT_RESET_BIT]);
		end
	end

	// enable sequencer; stopping waits on the frame, not on software
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			en_state_ff <= EN_OFF;
		end else if (soft_rst_ff) begin
			en_state_ff <= EN_OFF;
		end else begin
			case (en_state_ff)
				EN_OFF: begin
					if (ctrl_ff[CGC_ENA_BIT]) begin
						en_state_ff <= EN_STARTING;
					end
				end
				EN_STARTING: begin
					if (!ctrl_ff[CGC_ENA_BIT]) begin
						en_state_ff <= EN_OFF;
					end else if (start_done) begin
						en_state_ff <= EN_ON;
					end
				end
				EN_ON: begin
					if (!ctrl_ff[CGC_ENA_BIT]) begin
						en_state_ff <= EN_STOPPING;
					end
				end
				EN_STOPPING: begin
					// a frame under way is finished before the freeze
					if (ctrl_ff[CGC_ENA_BIT]) begin
						en_state_ff <= EN_ON;
					end else if (!FRAME_ACTIVE) begin
						en_state_ff <= EN_OFF;
					end
				end
				default: begin
					en_state_ff <= EN_OFF;
				end
			endcase
		end
	end

	// engine run, clock gate and receiver enable follow the sequencer
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ENG_RUN <= 1'b0;
			CLK_GATE_EN <= 1'b0;
			RX_ENABLE <= 1'b0;
		end else begin
			ENG_RUN <= enabled;
			CLK_GATE_EN <= (en_state_ff != EN_OFF);
			RX_ENABLE <= enabled;
		end
	end

	// bus pins: transmit recessive in standby and in listening mode, receive bit recessive in standby only
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			CAN_TX <= CGC_RECESSIVE;
			RX_DATA <= CGC_RECESSIVE;
		end else begin
			if (!enabled || ctrl_ff[CGC_LISTEN_BIT]) begin
				CAN_TX <= CGC_RECESSIVE;
			end else begin
				CAN_TX <= ENG_TX_BIT & ENG_ACK_BIT;
			end
			RX_DATA <= enabled ? rx_sync : CGC_RECESSIVE;
		end
	end

	// abort: one clearing pulse per set, pending drop as a level
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			abort_seen_ff <= 1'b0;
			OBJ_EN_CLR <= 1'b0;
			TX_ABORT <= 1'b0;
		end else begin
			abort_seen_ff <= ctrl_ff[CGC_ABORT_REQUEST_BIT];
			OBJ_EN_CLR <= ctrl_ff[CGC_ABORT_REQUEST_BIT] && !abort_seen_ff;
			TX_ABORT <= ctrl_ff[CGC_ABORT_REQUEST_BIT];
		end
	end

	// completion flags pass through whatever the abort state
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			TRANSMIT_OK_FLAG_SET <= 1'b0;
			RECEIVE_OK_FLAG_SET <= 1'b0;
		end else begin
			TRANSMIT_OK_FLAG_SET <= TX_DONE;
			RECEIVE_OK_FLAG_SET <= RX_DONE;
		end
	end

	// overload arming: request plus a received message; the start pulse ends it
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ovl_pending_ff <= 1'b0;
		end else if (soft_rst_ff || OVL_TX_START || !ctrl_ff[CGC_OVERLOAD_REQUEST_BIT]) begin
			ovl_pending_ff <= 1'b0;
		end else if (RX_MSG_DONE) begin
			ovl_pending_ff <= 1'b1;
		end
	end

	// mode outputs and the timer capture strobe
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			OVL_FRAME_REQ <= 1'b0;
			TTC_MODE <= 1'b0;
			TIMER_CAPTURE <= 1'b0;
			LISTEN_MODE <= 1'b0;
			ERR_CNT_FREEZE <= 1'b0;
		end else begin
			OVL_FRAME_REQ <= ovl_pending_ff && !OVL_TX_START;
			TTC_MODE <= ctrl_ff[CGC_TTC_BIT];
			// select only counts in time-triggered mode
			if (ctrl_ff[CGC_TTC_BIT] && enabled) begin
				TIMER_CAPTURE <= ctrl_ff[CGC_SYNC_BIT] ? EOF_LAST : SOF_SEEN;
			end else begin
				TIMER_CAPTURE <= 1'b0;
			end
			LISTEN_MODE <= ctrl_ff[CGC_LISTEN_BIT];
			ERR_CNT_FREEZE <= ctrl_ff[CGC_LISTEN_BIT];
		end
	end

	// status image; reserved bits read zero
	always_comb begin
		stat_word = 8'h00;
		stat_word[CGC_OVFG_BIT] = OVL_TX_ACTIVE;
		stat_word[CGC_TBSY_BIT] = TX_BUSY;
		stat_word[CGC_RBSY_BIT] = RX_BUSY;
		stat_word[CGC_ENABLED_STATE_FLAG_BIT] = enabled;
		stat_word[CGC_BOFF_BIT] = BUS_OFF;
		stat_word[CGC_ERRP_BIT] = ERR_PASSIVE;
	end

	// registered read port; other addresses answer zero
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			SFR_RDATA <= 8'h00;
		end else if (SFR_RD) begin
			case (SFR_ADDR)
				CGC_CTRL_ADDR: begin
					SFR_RDATA <= ctrl_ff;
				end
				CGC_STAT_ADDR: begin
					SFR_RDATA <= stat_word;
				end
				default: begin
					SFR_RDATA <= CGC_UNMAPPED_DATA;
				end
			endcase
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	property p_abort_clr;
		$rose(ctrl_ff[CGC_ABORT_REQUEST_BIT]) |=> OBJ_EN_CLR && TX_ABORT;
	endproperty
	a_abort_clr: assert property (p_abort_clr) else $error("abort did not clear objects");

	property p_abort_hold;
		ctrl_ff[CGC_ABORT_REQUEST_BIT] && !ctrl_wr && !soft_rst_ff |=> ctrl_ff[CGC_ABORT_REQUEST_BIT];
	endproperty
	a_abort_hold: assert property (p_abort_hold) else $error("abort bit cleared itself");

	property p_ovl_clear;
		OVL_TX_START && !ctrl_wr |=> !ctrl_ff[CGC_OVERLOAD_REQUEST_BIT] ##1 !OVL_FRAME_REQ;
	endproperty
	a_ovl_clear: assert property (p_ovl_clear) else $error("overload request stuck");

	property p_ovl_arm;
		ctrl_ff[CGC_OVERLOAD_REQUEST_BIT] && RX_MSG_DONE && !OVL_TX_START && !soft_rst_ff |=> ##1 OVL_FRAME_REQ;
	endproperty
	a_ovl_arm: assert property (p_ovl_arm) else $error("overload not armed");

	property p_no_capture;
		!ctrl_ff[CGC_TTC_BIT] |=> !TIMER_CAPTURE;
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("capture outside ttc");

	property p_capture_sel;
		ctrl_ff[CGC_TTC_BIT] && enabled && ctrl_ff[CGC_SYNC_BIT] |=> TIMER_CAPTURE == $past(EOF_LAST);
	endproperty
	a_capture_sel: assert property (p_capture_sel) else $error("wrong capture point");

	property p_standby_tx;
		!enabled |=> CAN_TX == CGC_RECESSIVE && RX_DATA == CGC_RECESSIVE;
	endproperty
	a_standby_tx: assert property (p_standby_tx) else $error("bus driven in standby");

	property p_listen_tx;
		ctrl_ff[CGC_LISTEN_BIT] |=> CAN_TX == CGC_RECESSIVE && ERR_CNT_FREEZE;
	endproperty
	a_listen_tx: assert property (p_listen_tx) else $error("listening node drove bus");

	property p_start_two;
		en_state_ff == EN_OFF ##1 en_state_ff == EN_STARTING |-> !enabled [*3] ##1 enabled;
	endproperty
	a_start_two: assert property (p_start_two) else $error("start delay wrong");

	property p_stop_waits;
		en_state_ff == EN_STOPPING && FRAME_ACTIVE && !ctrl_ff[CGC_ENA_BIT] && !soft_rst_ff
			|=> enabled;
	endproperty
	a_stop_waits: assert property (p_stop_waits) else $error("frame cut by disable");

	property p_soft_rst;
		ctrl_wr && SFR_WDATA[CGC_SOFT_RESET_BIT] |=> !CORE_RST_B && soft_rst_ff ##1 CORE_RST_B && ctrl_ff == CGC_CTRL_RST;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset misbehaved");

	c_enable_run: cover property (en_state_ff == EN_STARTING ##[1:4] ENG_RUN);
	c_abort: cover property (OBJ_EN_CLR ##[1:20] TRANSMIT_OK_FLAG_SET);
	c_overload: cover property (OVL_FRAME_REQ ##[1:20] OVL_TX_START);
	c_stop: cover property (en_state_ff == EN_STOPPING ##[1:20] en_state_ff == EN_OFF);
endmodule

// file: core/cgc_pkg.sv
package cgc_pkg;
	// special-function addresses of the two registers
	localparam logic [7:0] CGC_CTRL_ADDR = 8'hab; // general_control_reg
	localparam logic [7:0] CGC_STAT_ADDR = 8'haa; // general_status_reg, read only
	// general_control_reg bit positions
	localparam int CGC_ABORT_REQUEST_BIT = 7; // abort_request
	localparam int CGC_OVERLOAD_REQUEST_BIT = 6; // overload_request
	localparam int CGC_TTC_BIT = 5; // time_triggered_mode
	localparam int CGC_SYNC_BIT = 4; // trigger_capture_select
	localparam int CGC_LISTEN_BIT = 3; // listening mode
	localparam int CGC_TEST_BIT = 2; // factory test mode
	localparam int CGC_ENA_BIT = 1; // controller_enable
	localparam int CGC_SOFT_RESET_BIT = 0; // soft_reset
	// general_status_reg bit positions
	localparam int CGC_OVFG_BIT = 6; // overload frame being sent
	localparam int CGC_TBSY_BIT = 4; // transmitter busy
	localparam int CGC_RBSY_BIT = 3; // receiver busy
	localparam int CGC_ENABLED_STATE_FLAG_BIT = 2; // enabled_state_flag
	localparam int CGC_BOFF_BIT = 1; // bus off
	localparam int CGC_ERRP_BIT = 0; // error passive
	// reset values and constants
	localparam logic [7:0] CGC_CTRL_RST = 8'h00; // control register after reset
	localparam logic [7:0] CGC_UNMAPPED_DATA = 8'h00; // read of any other address
	localparam logic CGC_RECESSIVE = 1'b1; // recessive bus level
	localparam logic [1:0] CGC_START_CYCLES = 2'h2; // start delay clocks counted before done
	// enable/standby sequencing
	typedef enum logic [1:0] {
		EN_OFF,
		EN_STARTING,
		EN_ON,
		EN_STOPPING
	} cgc_en_state_type;
endpackage

// file: core/cgc_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for a pin level
module cgc_sync2 (
	input wire logic clk, // controller clock
	input wire logic rst_b, // async reset, active low
	input wire logic rst_val, // reset level, unused; both flops reset to 1
	input wire logic d_in, // asynchronous level
	output logic q_out // synchronised level
);
	logic meta_ff; // first stage, read only by the second stage
	// metastability guard; rst_val is tied to a literal at the instance
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 1'b1;
			q_out <= 1'b1;
		end else begin
			meta_ff <= d_in;
			q_out <= meta_ff;
		end
	end
endmodule

// file: core/cgc_delay_cnt.sv
`timescale 1ns/1ps
// counts a fixed number of clocks while start is held, then raises done
module cgc_delay_cnt import cgc_pkg::*; (
	input wire logic clk, // controller clock
	input wire logic rst_b, // async reset, active low
	input wire logic start, // hold high to count; low clears
	output logic done // high once the count has elapsed
);
	logic [1:0] cnt_ff; // elapsed clocks
	logic [1:0] nxt_cnt; // next count
	// saturate at the target so done stays high while start holds
	always_comb begin
		nxt_cnt = cnt_ff;
		if (!start) begin
			nxt_cnt = 2'h0;
		end else if (cnt_ff != CGC_START_CYCLES) begin
			nxt_cnt = cnt_ff + 2'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	assign done = start && (cnt_ff == CGC_START_CYCLES);
endmodule

// file: tb/cgc_can_node.sv
`timescale 1ns/1ps
// far node on the bus: wired-and with our transmitter
module cgc_can_node (
	input wire logic tx_pin, // our transmit pin
	input wire logic drive_dom, // far node sends dominant
	output logic rx_pin // bus level seen by our receiver
);
	// pull-up keeps the bus recessive when nobody drives dominant
	assign rx_pin = tx_pin & ~drive_dom;
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cgc_pkg::*;
	logic mclk = 1'b0; // controller clock
	logic rst_b = 1'b0; // hardware reset
	logic [7:0] addr = 8'h00; // register address
	logic [7:0] wdata = 8'h00; // write data
	logic wr = 1'b0; // write strobe
	logic rd = 1'b0; // read strobe
	logic tx_bit = 1'b1; // engine transmit bit
	logic frame = 1'b0; // frame in progress
	logic [5:0] ev = 6'h00; // engine event pulses
	logic [5:0] lv = 6'h20; // ack and status levels
	logic dom = 1'b0; // far node dominant
	logic [7:0] rdata, v; // read data, scratch
	wire logic [7:0] mon; // watched outputs, one port per bit
	logic can_rx, can_tx, rx_data, rx_en, time_triggered_mode, listen, frz, tx_abort;
	int n_mismatch = 0;
	int checks_done = 0;
	// 40 ns period
	always #20 mclk = ~mclk;
	cgc_can_node node (.tx_pin(can_tx), .drive_dom(dom), .rx_pin(can_rx));
	cgc_top dut (.MCLK(mclk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WDATA(wdata),
		.SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .CAN_RX(can_rx), .CAN_TX(can_tx),
		.ENG_TX_BIT(tx_bit), .ENG_ACK_BIT(lv[5]), .FRAME_ACTIVE(frame),
		.RX_MSG_DONE(ev[0]), .OVL_TX_START(ev[1]), .OVL_TX_ACTIVE(lv[4]),
		.SOF_SEEN(ev[2]), .EOF_LAST(ev[3]), .TX_DONE(ev[4]), .RX_DONE(ev[5]),
		.TX_BUSY(lv[3]), .RX_BUSY(lv[2]), .BUS_OFF(lv[1]), .ERR_PASSIVE(lv[0]),
		.RX_DATA(rx_data), .RX_ENABLE(rx_en), .ENG_RUN(mon[0]), .CLK_GATE_EN(mon[1]),
		.CORE_RST_B(mon[2]), .OBJ_EN_CLR(mon[3]), .TX_ABORT(tx_abort),
		.OVL_FRAME_REQ(mon[4]), .TTC_MODE(time_triggered_mode), .TIMER_CAPTURE(mon[5]),
		.LISTEN_MODE(listen), .ERR_CNT_FREEZE(frz), .TRANSMIT_OK_FLAG_SET(mon[6]), .RECEIVE_OK_FLAG_SET(mon[7]));
	// closing report, the only exit
	task print_verdict();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// compare and count
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one write; strobe dropped at its own sampling edge
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// one read; data taken after it has landed
	task rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		#1 d = rdata;
	endtask
	// one-cycle engine event, returns just after its sampling edge
	task pulse(input int i);
		@(posedge mclk);
		ev[i] <= 1'b1;
		@(posedge mclk);
		ev[i] <= 1'b0;
		#1;
	endtask
	// bounded wait for a watched output; running out ends the run
	task wait_bit(input int i, input logic val, input int lim);
		int k;
		#1;
		for (k = 0; k < lim && mon[i] !== val; k++) begin
			@(posedge mclk);
			#1;
		end
		chk($sformatf("mon%0d", i), {7'h00, mon[i]}, {7'h00, val});
		if (mon[i] !== val) print_verdict();
	endtask
	// reset values, status pass-through, unmapped and read-only places
	task t_reset();
		dom <= 1'b1;
		lv <= 6'h3a;
		rd_reg(CGC_CTRL_ADDR, v);
		chk("ctrl", v, 8'h00);
		chk("gate", {7'h00, mon[1]}, 8'h00);
		chk("tx", {7'h00, can_tx}, 8'h01);
		chk("rxd", {7'h00, rx_data}, 8'h01);
		wr_reg(CGC_STAT_ADDR, 8'hff);
		rd_reg(CGC_STAT_ADDR, v);
		chk("stat", v, 8'h52);
		lv <= 6'h25;
		rd_reg(CGC_STAT_ADDR, v);
		chk("stat2", v, 8'h09);
		rd_reg(8'h55, v);
		chk("unmapped", v, CGC_UNMAPPED_DATA);
		lv <= 6'h20;
	endtask
	// enable: clock first, engine later, receiver and driver follow
	task t_enable();
		tx_bit <= 1'b0;
		wr_reg(CGC_CTRL_ADDR, 8'h02); // test bit kept clear
		wait_bit(1, 1'b1, 8);
		chk("run early", {7'h00, mon[0]}, 8'h00);
		wait_bit(0, 1'b1, 8);
		repeat (3) @(posedge mclk);
		#1 chk("rxen", {7'h00, rx_en}, 8'h01);
		chk("rxd", {7'h00, rx_data}, 8'h00);
		chk("tx", {7'h00, can_tx}, 8'h00);
		rd_reg(CGC_STAT_ADDR, v);
		chk("enabled_state_flag", v, 8'h04);
		dom <= 1'b0;
	endtask
	// capture point per mode and select
	task t_capture();
		logic [7:0] c [5] = '{8'h22, 8'h22, 8'h32, 8'h32, 8'h12};
		int e [5] = '{2, 3, 3, 2, 3};
		logic x [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		for (int j = 0; j < 5; j++) begin
			wr_reg(CGC_CTRL_ADDR, c[j]);
			repeat (2) @(posedge mclk);
			pulse(e[j]);
			chk("capture", {7'h00, mon[5]}, {7'h00, x[j]});
			chk("ttc", {7'h00, time_triggered_mode}, {7'h00, c[j][5]});
		end
	endtask
	// abort mid-frame: ongoing frame still flags ok, bit sticks
	task t_abort();
		frame <= 1'b1;
		wr_reg(CGC_CTRL_ADDR, 8'h82);
		wait_bit(3, 1'b1, 4);
		chk("abort", {7'h00, tx_abort}, 8'h01);
		@(posedge mclk);
		#1 chk("clr pulse", {7'h00, mon[3]}, 8'h00);
		pulse(4);
		wait_bit(6, 1'b1, 3);
		pulse(5);
		wait_bit(7, 1'b1, 3);
		repeat (10) @(posedge mclk);
		rd_reg(CGC_CTRL_ADDR, v);
		chk("abort held", v, 8'h82);
		wr_reg(CGC_CTRL_ADDR, 8'h02);
		frame <= 1'b0;
		wait_bit(3, 1'b0, 4);
		repeat (2) @(posedge mclk);
		#1 chk("abort off", {7'h00, tx_abort}, 8'h00);
	endtask
	// overload armed by a received message, cleared when it starts
	task t_overload();
		wr_reg(CGC_CTRL_ADDR, 8'h42);
		repeat (4) @(posedge mclk);
		#1 chk("ovl early", {7'h00, mon[4]}, 8'h00);
		pulse(0);
		wait_bit(4, 1'b1, 4);
		pulse(1);
		wait_bit(4, 1'b0, 3);
		rd_reg(CGC_CTRL_ADDR, v);
		chk("ovl bit", v, 8'h02);
	endtask
	// listening: no driving, counters held
	task t_listen();
		wr_reg(CGC_CTRL_ADDR, 8'h0a);
		repeat (3) @(posedge mclk);
		#1 chk("listen", {6'h00, listen, frz}, 8'h03);
		chk("tx quiet", {7'h00, can_tx}, 8'h01);
		wr_reg(CGC_CTRL_ADDR, 8'h02);
		repeat (3) @(posedge mclk);
		#1 chk("listen off", {7'h00, listen}, 8'h00);
		tx_bit <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk("tx follows", {7'h00, can_tx}, 8'h01);
		lv <= 6'h00;
		repeat (2) @(posedge mclk);
		#1 chk("tx ack", {7'h00, can_tx}, 8'h00);
		lv <= 6'h20;
		tx_bit <= 1'b0;
	endtask
	// disable during a frame: engine runs until the frame ends
	task t_disable();
		frame <= 1'b1;
		wr_reg(CGC_CTRL_ADDR, 8'h00);
		repeat (6) @(posedge mclk);
		#1 chk("run held", {7'h00, mon[0]}, 8'h01);
		// re-enable while stopping: engine must not restart from off
		wr_reg(CGC_CTRL_ADDR, 8'h02);
		repeat (3) @(posedge mclk);
		#1 chk("run back", {7'h00, mon[0]}, 8'h01);
		chk("gate back", {7'h00, mon[1]}, 8'h01);
		wr_reg(CGC_CTRL_ADDR, 8'h00);
		repeat (3) @(posedge mclk);
		frame <= 1'b0;
		wait_bit(0, 1'b0, 6);
		wait_bit(1, 1'b0, 6);
		chk("tx stby", {7'h00, can_tx}, 8'h01);
		chk("rx stby", {7'h00, rx_en}, 8'h00);
		rd_reg(CGC_STAT_ADDR, v);
		chk("enabled_state_flag off", v, 8'h00);
	endtask
	// soft reset while enabled and listening
	task t_soft();
		wr_reg(CGC_CTRL_ADDR, 8'h02);
		wait_bit(0, 1'b1, 10);
		wr_reg(CGC_CTRL_ADDR, 8'h0b);
		wait_bit(2, 1'b0, 3);
		wait_bit(2, 1'b1, 3);
		rd_reg(CGC_CTRL_ADDR, v);
		chk("after soft", v, 8'h00);
		wait_bit(1, 1'b0, 3);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_enable();
		t_capture();
		t_abort();
		t_overload();
		t_listen();
		t_disable();
		t_soft();
		print_verdict();
	end
endmodule
